// ===== rtl/bt_consts.svh
/*
 * lengths in bytes and execution times in system clocks for the
 * program-branching group, plus the datapath widths.
 * assumes: included by the bt package only, by bare name.
 */
`ifndef BT_CONSTS_SVH
`define BT_CONSTS_SVH

`define BT_PC_W        16
`define BT_LEN_W       2
`define BT_CYC_W       3

// byte lengths
`define BT_LEN_INT_RTN 2'h1
`define BT_LEN_SUB_RTN 2'h1
`define BT_LEN_ABS     2'h2
`define BT_LEN_LONG    2'h3
`define BT_LEN_SHORT   2'h2
`define BT_LEN_IDX     2'h1
`define BT_LEN_ACCZ    2'h2
`define BT_LEN_CMP     2'h3
`define BT_LEN_DEC_REG 2'h2
`define BT_LEN_DEC_DIR 2'h3
`define BT_LEN_CALL    2'h3

// clocks; the conditional ones as not-taken / taken pairs
`define BT_CYC_INT_RTN 3'h5
`define BT_CYC_SUB_RTN 3'h5
`define BT_CYC_ABS     3'h3
`define BT_CYC_LONG    3'h4
`define BT_CYC_SHORT   3'h3
`define BT_CYC_IDX     3'h3
`define BT_CYC_CALL    3'h4
`define BT_NT_ACCZ     3'h2
`define BT_TK_ACCZ     3'h3
`define BT_NT_CMP_DIR  3'h4
`define BT_TK_CMP_DIR  3'h5
`define BT_NT_CMP_IMM  3'h3
`define BT_TK_CMP_IMM  3'h4
`define BT_NT_DEC_REG  3'h2
`define BT_TK_DEC_REG  3'h3
`define BT_NT_DEC_DIR  3'h3
`define BT_TK_DEC_DIR  3'h4
`define BT_CYC_ILLEGAL 3'h1

`endif

// ===== rtl/bt_pkg.sv
/*
 * types and timing lookups shared by the branch decoder files.
 * assumes: bt_consts.svh is on the include path.
 */
package bt_pkg;
`include "bt_consts.svh"

    typedef enum logic [3:0] {
        BT_OP_INT_RTN,
        BT_OP_SUB_RTN,
        BT_OP_ABS,
        BT_OP_LONG,
        BT_OP_SHORT,
        BT_OP_IDX,
        BT_OP_ACC_ZERO,
        BT_OP_ACC_NZ,
        BT_OP_CMP_DIR,
        BT_OP_CMP_ACC,
        BT_OP_CMP_REG,
        BT_OP_CMP_IND,
        BT_OP_DEC_REG,
        BT_OP_DEC_DIR,
        BT_OP_CALL
    } bt_op_e;

    // one fetched branch instruction
    typedef struct packed {
        bt_op_e                op;
        logic [2:0]            hi3;  // upper target bits of 11-bit jump
        logic [7:0]            b1;
        logic [7:0]            b2;
        logic [`BT_PC_W-1:0]   pc;   // address of the opcode byte
    } bt_issue_s;

    // decoded outcome handed to pc and stack logic
    typedef struct packed {
        logic [`BT_PC_W-1:0]   next_pc;
        logic [`BT_PC_W-1:0]   ret_pc;
        logic [`BT_LEN_W-1:0]  len;
        logic [`BT_CYC_W-1:0]  cyc;
        logic                  taken;
        logic                  push;
        logic                  pop;
        logic                  int_done;
        logic                  dec_we;
        logic [7:0]            dec_val;
    } bt_result_s;

    function automatic logic [`BT_LEN_W-1:0] bt_len(bt_op_e op);
        unique case (op)
            BT_OP_INT_RTN:                  return `BT_LEN_INT_RTN;
            BT_OP_SUB_RTN:                  return `BT_LEN_SUB_RTN;
            BT_OP_ABS:                      return `BT_LEN_ABS;
            BT_OP_LONG:                     return `BT_LEN_LONG;
            BT_OP_SHORT:                    return `BT_LEN_SHORT;
            BT_OP_IDX:                      return `BT_LEN_IDX;
            BT_OP_ACC_ZERO, BT_OP_ACC_NZ:   return `BT_LEN_ACCZ;
            BT_OP_DEC_REG:                  return `BT_LEN_DEC_REG;
            BT_OP_DEC_DIR:                  return `BT_LEN_DEC_DIR;
            BT_OP_CALL:                     return `BT_LEN_CALL;
            default:                        return `BT_LEN_CMP;
        endcase
    endfunction

    // not-taken count is the smaller of each pair
    function automatic logic [`BT_CYC_W-1:0] bt_cycles(bt_op_e op,
                                                       logic   tk);
        unique case (op)
            BT_OP_INT_RTN:  return `BT_CYC_INT_RTN;
            BT_OP_SUB_RTN:  return `BT_CYC_SUB_RTN;
            BT_OP_ABS:      return `BT_CYC_ABS;
            BT_OP_LONG:     return `BT_CYC_LONG;
            BT_OP_SHORT:    return `BT_CYC_SHORT;
            BT_OP_IDX:      return `BT_CYC_IDX;
            BT_OP_CALL:     return `BT_CYC_CALL;
            BT_OP_ACC_ZERO, BT_OP_ACC_NZ:
                return tk ? `BT_TK_ACCZ : `BT_NT_ACCZ;
            BT_OP_CMP_DIR:
                return tk ? `BT_TK_CMP_DIR : `BT_NT_CMP_DIR;
            BT_OP_CMP_ACC, BT_OP_CMP_REG, BT_OP_CMP_IND:
                return tk ? `BT_TK_CMP_IMM : `BT_NT_CMP_IMM;
            BT_OP_DEC_REG:
                return tk ? `BT_TK_DEC_REG : `BT_NT_DEC_REG;
            BT_OP_DEC_DIR:
                return tk ? `BT_TK_DEC_DIR : `BT_NT_DEC_DIR;
            default:        return `BT_CYC_ILLEGAL;
        endcase
    endfunction
endpackage

// ===== rtl/bt_target.sv
/*
 * candidate branch targets for one instruction: sequential, relative,
 * 11-bit absolute, 16-bit long and accumulator-indexed.
 * assumes: issue fields are stable while the decoder samples them.
 */
`timescale 1ns/1ns
module bt_target
    import bt_pkg::*;
(
    // instruction
    input  wire bt_issue_s              issue,
    input  wire logic [`BT_LEN_W-1:0]   len,
    // core state
    input  wire logic [7:0]             acc,
    input  wire logic [`BT_PC_W-1:0]    data_pointer,
    // targets
    output logic      [`BT_PC_W-1:0]    seq_pc,
    output logic      [`BT_PC_W-1:0]    rel_pc,
    output logic      [`BT_PC_W-1:0]    abs_pc,
    output logic      [`BT_PC_W-1:0]    long_pc,
    output logic      [`BT_PC_W-1:0]    idx_pc
);
    logic [7:0] rel;

    // offset is the last byte of the instruction
    assign rel     = (len == `BT_LEN_CMP) ? issue.b2 : issue.b1;
    assign seq_pc  = issue.pc + {14'h0000, len};
    // offset counts from the following instruction, sign extended
    assign rel_pc  = seq_pc + {{8{rel[7]}}, rel};
    // stays inside the 2 KB block of the following instruction
    assign abs_pc  = {seq_pc[15:11], issue.hi3, issue.b1};
    assign long_pc = {issue.b1, issue.b2};
    assign idx_pc  = data_pointer + {8'h00, acc};
endmodule

// ===== rtl/bt_cycle_timer.sv
/*
 * holds the decoder busy for a loaded number of system clocks and
 * pulses done in the last of them.
 * assumes: load is only raised while busy is low; count is at least 1.
 */
`timescale 1ns/1ns
module bt_cycle_timer #(
    parameter int CW = 3
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // control
    input  wire logic          load,
    input  wire logic [CW-1:0] count,
    // status
    output logic               busy_r,
    output logic               done_r
);
    logic [CW-1:0] left_r;

    // remaining clocks, current one included
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            left_r <= '0;
        else if (load)
            left_r <= count;
        else if (left_r != '0)
            left_r <= left_r - CW'(1);
    end

    // busy and done as flops so the top drives them cleanly
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else if (load)
        begin
            busy_r <= 1'b1;
            done_r <= (count == CW'(1));
        end
        else
        begin
            busy_r <= (left_r > CW'(1));
            done_r <= (left_r == CW'(2));
        end
    end
endmodule

// ===== rtl/bt_branch_decoder.sv
/*
 * branch-group decoder of the pipelined core: takes one fetched
 * branch instruction, fixes its length, outcome, target and time.
 * assumes: the core presents operand values with the issue and only
 * issues while BUSY is low; stack and register writes happen outside.
 */
`timescale 1ns/1ns

module bt_branch_decoder
    import bt_pkg::*;
(
    // clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESETN,
    // instruction from fetch
    input  wire logic                  ISSUE_VALID,
    input  wire bt_issue_s             ISSUE,
    // core state read by the branch
    input  wire logic [7:0]            ACC,
    input  wire logic [`BT_PC_W-1:0]   DATA_POINTER_VAL,
    input  wire logic [7:0]            OPND,
    input  wire logic [`BT_PC_W-1:0]   STACK_PC,
    // outcome to pc and stack logic
    output logic                       BUSY,
    output logic                       DONE,
    output bt_result_s                 RESULT
);
    logic                 accept;
    logic                 busy_r;
    logic                 done_r;
    logic                 taken;
    logic [7:0]           dec_val;
    logic [`BT_LEN_W-1:0] len;
    logic [`BT_CYC_W-1:0] cyc;
    logic [`BT_PC_W-1:0]  seq_pc;
    logic [`BT_PC_W-1:0]  rel_pc;
    logic [`BT_PC_W-1:0]  abs_pc;
    logic [`BT_PC_W-1:0]  long_pc;
    logic [`BT_PC_W-1:0]  idx_pc;
    bt_result_s           result_r;
    bt_result_s           result_nxt;

    // a new branch is only taken between instructions
    assign accept  = ISSUE_VALID && !busy_r;
    assign dec_val = OPND - 8'h01;
    assign len     = bt_len(ISSUE.op);
    assign cyc     = bt_cycles(ISSUE.op, taken);

    bt_target bt_target_i (
        .issue   (ISSUE),
        .len     (len),
        .acc     (ACC),
        .data_pointer    (DATA_POINTER_VAL),
        .seq_pc  (seq_pc),
        .rel_pc  (rel_pc),
        .abs_pc  (abs_pc),
        .long_pc (long_pc),
        .idx_pc  (idx_pc)
    );

    bt_cycle_timer #(
        .CW (`BT_CYC_W)
    ) bt_cycle_timer_i (
        .clk    (CORE_CLK),
        .rst_n  (RESETN),
        .load   (accept),
        .count  (cyc),
        .busy_r (busy_r),
        .done_r (done_r)
    );

    // branch condition per instruction
    always_comb
    begin
        unique case (ISSUE.op)
            BT_OP_ACC_ZERO: taken = (ACC == 8'h00);
            BT_OP_ACC_NZ:   taken = (ACC != 8'h00);
            BT_OP_CMP_DIR:  taken = (ACC != OPND);
            BT_OP_CMP_ACC:  taken = (ACC != ISSUE.b1);
            BT_OP_CMP_REG:  taken = (OPND != ISSUE.b1);
            BT_OP_CMP_IND:  taken = (OPND != ISSUE.b1);
            BT_OP_DEC_REG:  taken = (dec_val != 8'h00);
            BT_OP_DEC_DIR:  taken = (dec_val != 8'h00);
            default:        taken = 1'b1; // unconditional ones
        endcase
    end

    // target and side effects; not-taken falls through
    always_comb
    begin
        result_nxt          = '0;
        result_nxt.len      = len;
        result_nxt.cyc      = cyc;
        result_nxt.taken    = taken;
        result_nxt.ret_pc   = seq_pc;
        result_nxt.next_pc  = taken ? rel_pc : seq_pc;
        result_nxt.dec_val  = dec_val;
        unique case (ISSUE.op)
            BT_OP_INT_RTN:
            begin
                result_nxt.next_pc  = STACK_PC;
                result_nxt.pop      = 1'b1;
                result_nxt.int_done = 1'b1;
            end
            BT_OP_SUB_RTN:
            begin
                result_nxt.next_pc = STACK_PC;
                result_nxt.pop     = 1'b1;
            end
            BT_OP_ABS:  result_nxt.next_pc = abs_pc;
            BT_OP_LONG: result_nxt.next_pc = long_pc;
            BT_OP_IDX:  result_nxt.next_pc = idx_pc;
            BT_OP_CALL:
            begin
                result_nxt.next_pc = long_pc;
                result_nxt.push    = 1'b1;
            end
            // the decrement is written back whatever the outcome
            BT_OP_DEC_REG, BT_OP_DEC_DIR: result_nxt.dec_we = 1'b1;
            default: ;
        endcase
    end

    // outcome held for the whole execution time
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
            result_r <= '0;
        else if (accept)
            result_r <= result_nxt;
    end

    assign BUSY   = busy_r;
    assign DONE   = done_r;
    assign RESULT = result_r;

    // helper: clocks since the branch was accepted
    logic [`BT_CYC_W-1:0] age_r;
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
            age_r <= '0;
        else if (accept)
            age_r <= 3'h1;
        else if (busy_r)
            age_r <= age_r + 3'h1;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    property p_int_rtn;
        accept && ISSUE.op == BT_OP_INT_RTN |=> RESULT.len == 2'h1
            && RESULT.cyc == 3'h5 && RESULT.pop && RESULT.int_done
            && RESULT.next_pc == $past(STACK_PC);
    endproperty
    a_int_rtn: assert property (p_int_rtn)
        else $error("interrupt return decoded wrongly");

    property p_abs;
        accept && ISSUE.op == BT_OP_ABS |=> RESULT.len == 2'h2
            && RESULT.cyc == 3'h3
            && RESULT.next_pc[10:0] == {$past(ISSUE.hi3), $past(ISSUE.b1)};
    endproperty
    a_abs: assert property (p_abs)
        else $error("11-bit jump decoded wrongly");

    property p_long;
        accept && ISSUE.op == BT_OP_LONG |=> RESULT.len == 2'h3
            && RESULT.cyc == 3'h4
            && RESULT.next_pc == {$past(ISSUE.b1), $past(ISSUE.b2)};
    endproperty
    a_long: assert property (p_long)
        else $error("long jump decoded wrongly");

    property p_short;
        accept && ISSUE.op == BT_OP_SHORT |=> RESULT.len == 2'h2
            && RESULT.cyc == 3'h3 && RESULT.taken;
    endproperty
    a_short: assert property (p_short)
        else $error("short jump decoded wrongly");

    property p_idx;
        accept && ISSUE.op == BT_OP_IDX |=> RESULT.len == 2'h1
            && RESULT.cyc == 3'h3
            && RESULT.next_pc == $past(DATA_POINTER_VAL) + {8'h00, $past(ACC)};
    endproperty
    a_idx: assert property (p_idx)
        else $error("indexed jump decoded wrongly");

    property p_acc_zero;
        accept && ISSUE.op == BT_OP_ACC_ZERO |=> RESULT.len == 2'h2
            && RESULT.taken == ($past(ACC) == 8'h00);
    endproperty
    a_acc_zero: assert property (p_acc_zero)
        else $error("acc-zero branch decoded wrongly");

    property p_acc_nz;
        accept && ISSUE.op == BT_OP_ACC_NZ && ACC == 8'h00
            |=> RESULT.len == 2'h2 && !RESULT.taken && RESULT.cyc == 3'h2;
    endproperty
    a_acc_nz: assert property (p_acc_nz)
        else $error("acc-nonzero branch taken on zero");

    property p_cmp_dir;
        accept && ISSUE.op == BT_OP_CMP_DIR |=> RESULT.len == 2'h3
            && RESULT.cyc == (RESULT.taken ? 3'h5 : 3'h4);
    endproperty
    a_cmp_dir: assert property (p_cmp_dir)
        else $error("direct compare timing wrong");

    property p_cmp_acc;
        accept && ISSUE.op == BT_OP_CMP_ACC && ACC == ISSUE.b1
            |=> RESULT.len == 2'h3 && !RESULT.taken && RESULT.cyc == 3'h3;
    endproperty
    a_cmp_acc: assert property (p_cmp_acc)
        else $error("equal immediate compare branched");

    property p_cmp_reg;
        accept && ISSUE.op == BT_OP_CMP_REG && OPND != ISSUE.b1
            |=> RESULT.len == 2'h3 && RESULT.taken && RESULT.cyc == 3'h4;
    endproperty
    a_cmp_reg: assert property (p_cmp_reg)
        else $error("register compare missed inequality");

    property p_cmp_ind;
        accept && ISSUE.op == BT_OP_CMP_IND
            |=> RESULT.len == 2'h3
            && RESULT.cyc == (RESULT.taken ? 3'h4 : 3'h3);
    endproperty
    a_cmp_ind: assert property (p_cmp_ind)
        else $error("indirect compare timing wrong");

    property p_dec_reg;
        accept && ISSUE.op == BT_OP_DEC_REG && OPND == 8'h01
            |=> RESULT.len == 2'h2 && !RESULT.taken && RESULT.dec_we
            && RESULT.dec_val == 8'h00 && RESULT.cyc == 3'h2;
    endproperty
    a_dec_reg: assert property (p_dec_reg)
        else $error("register decrement to zero branched");

    property p_dec_dir;
        accept && ISSUE.op == BT_OP_DEC_DIR && OPND == 8'h00
            |=> RESULT.len == 2'h3 && RESULT.taken
            && RESULT.dec_val == 8'hff && RESULT.cyc == 3'h4;
    endproperty
    a_dec_dir: assert property (p_dec_dir)
        else $error("direct decrement wrap not taken");

    property p_call;
        accept && ISSUE.op == BT_OP_CALL |=> RESULT.len == 2'h3
            && RESULT.cyc == 3'h4 && RESULT.push
            && RESULT.ret_pc == $past(ISSUE.pc) + 16'h0003;
    endproperty
    a_call: assert property (p_call)
        else $error("long call decoded wrongly");

    property p_sub_rtn;
        accept && ISSUE.op == BT_OP_SUB_RTN |=> RESULT.len == 2'h1
            && RESULT.pop && !RESULT.int_done ##4 DONE;
    endproperty
    a_sub_rtn: assert property (p_sub_rtn)
        else $error("subroutine return not five clocks");

    property p_done_age;
        DONE |-> age_r == RESULT.cyc && BUSY ##1 !BUSY;
    endproperty
    a_done_age: assert property (p_done_age)
        else $error("done not at the decoded clock count");

    property p_rel_tgt;
        accept && ISSUE.op == BT_OP_SHORT |=> RESULT.next_pc ==
            $past(ISSUE.pc) + 16'h0002
            + {{8{$past(ISSUE.b1[7])}}, $past(ISSUE.b1)};
    endproperty
    a_rel_tgt: assert property (p_rel_tgt)
        else $error("relative target miscomputed");

    c_cmp_taken: cover property (accept && ISSUE.op == BT_OP_CMP_DIR
        && ACC != OPND);
    c_dec_fall: cover property (accept && ISSUE.op == BT_OP_DEC_REG
        && OPND == 8'h01);
    c_call: cover property (accept && ISSUE.op == BT_OP_CALL);
    c_back: cover property (DONE ##1 accept);
endmodule

// ===== testbench/bt_branch_decoder_test.sv
/*
 * self-checking bench for the branch-group decoder: every branch kind,
 * the conditional ones through both outcomes, back to back, and a reset in mid-instruction.
 * assumes: bt_pkg and the decoder are compiled first; the assertions
 * live beside the design logic, so no checker is bound here.
 */
`timescale 1ns/1ns

`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("unexpected at %0t: got %h expected %h", \
                     $time, (g), (e)); \
        end \
    end

module branch_instruction_timing_test
    import bt_pkg::*;
;
    // clock and reset
    logic                core_clk;
    logic                resetn;
    // instruction and core state
    logic                issue_valid;
    bt_issue_s           issue;
    logic [7:0]          acc;
    logic [`BT_PC_W-1:0] data_pointer_val;
    logic [7:0]          opnd;
    logic [`BT_PC_W-1:0] stack_pc;
    // outcome
    logic                busy;
    logic                done;
    bt_result_s          result;
    // scenario state and bookkeeping
    logic [15:0]         pc_v;
    logic [2:0]          hi3_v;
    bit                  chain_v;
    int                  err_count;
    int                  n_tests;

    // free-running system clock, 10 ns period
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    bt_branch_decoder bt_branch_decoder_i (
        .CORE_CLK    (core_clk),
        .RESETN      (resetn),
        .ISSUE_VALID (issue_valid),
        .ISSUE       (issue),
        .ACC         (acc),
        .DATA_POINTER_VAL    (data_pointer_val),
        .OPND        (opnd),
        .STACK_PC    (stack_pc),
        .BUSY        (busy),
        .DONE        (done),
        .RESULT      (result)
    );

    // relative target: offset counts from the following instruction
    function automatic logic [15:0] rel(logic [1:0] len, logic [7:0] off);
        return pc_v + {14'h0, len} + {{8{off[7]}}, off};
    endfunction

    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // issue one instruction and follow it to its last busy cycle;
    // bb holds the two operand bytes, ao holds acc and operand value
    task automatic go(bt_op_e op, logic [15:0] bb, logic [15:0] ao,
                      logic [1:0] elen, logic [2:0] ecyc, logic etk,
                      logic [15:0] enext);
        bit         ok;
        bt_result_s r1;
        logic       is_dec;
        is_dec = (op == BT_OP_DEC_REG) || (op == BT_OP_DEC_DIR);
        ok = 1'b0;
        issue = '{op: op, hi3: hi3_v, b1: bb[15:8], b2: bb[7:0], pc: pc_v};
        acc = ao[15:8];
        opnd = ao[7:0];
        issue_valid = 1'b1;
        // accept edge: the first one that finds busy low; the edge
        // ending the done cycle still sees busy high and refuses
        for (int w = 0; w < 10 && !ok; w++)
        begin
            ok = (busy === 1'b0);
            @(posedge core_clk);
            // look again only once the edge's updates have settled
            if (!ok)
                #1;
        end
        if (!ok)
        begin
            err_count++;
            summarize();
        end
        #1;
        // in a chain the request stays up with changed state while busy
        if (chain_v)
        begin
            acc = ~ao[15:8];
            opnd = ~ao[7:0];
        end
        else
            issue_valid = 1'b0;
        r1 = result;
        `CHK(result.len, elen)
        `CHK(result.cyc, ecyc)
        `CHK(result.taken, etk)
        `CHK(result.next_pc, enext)
        `CHK(result.ret_pc, pc_v + {14'h0, elen})
        `CHK(result.push, op == BT_OP_CALL)
        `CHK(result.pop, op == BT_OP_INT_RTN || op == BT_OP_SUB_RTN)
        `CHK(result.int_done, op == BT_OP_INT_RTN)
        `CHK(result.dec_we, is_dec)
        if (is_dec)
            `CHK(result.dec_val, ao[7:0] - 8'h01)
        // busy for exactly ecyc cycles, done only in the last
        for (int k = 1; k <= ecyc; k++)
        begin
            `CHK(busy, 1'b1)
            `CHK(done, k == ecyc)
            `CHK(result, r1)
            if (k < ecyc)
                @(posedge core_clk) #1;
        end
        if (!chain_v)
        begin
            @(posedge core_clk) #1;
            `CHK(busy, 1'b0)
            `CHK(done, 1'b0)
        end
    endtask

    // returns, jumps and the call
    task automatic s_uncond();
        stack_pc = 16'h1234;
        go(BT_OP_INT_RTN, 16'h0000, 16'h0000, 2'h1, 3'h5, 1'b1,
           16'h1234);
        stack_pc = 16'h0abc;
        go(BT_OP_SUB_RTN, 16'h0000, 16'h0000, 2'h1, 3'h5, 1'b1,
           16'h0abc);
        // block bits come from the address after the jump
        pc_v = 16'h27fe;
        hi3_v = 3'h5;
        go(BT_OP_ABS, 16'h3c00, 16'h0000, 2'h2, 3'h3, 1'b1,
           16'h2d3c);
        pc_v = 16'h2000;
        hi3_v = 3'h0;
        go(BT_OP_LONG, 16'hbeef, 16'h0000, 2'h3, 3'h4, 1'b1,
           16'hbeef);
        go(BT_OP_CALL, 16'h1234, 16'h0000, 2'h3, 3'h4, 1'b1,
           16'h1234);
        go(BT_OP_SHORT, 16'h8000, 16'h0000, 2'h2, 3'h3, 1'b1,
           16'h1f82);
        data_pointer_val = 16'hfff0;
        go(BT_OP_IDX, 16'h0000, 16'hf000, 2'h1, 3'h3, 1'b1,
           16'h00e0);
    endtask

    // each conditional branch both ways
    task automatic s_cond();
        go(BT_OP_ACC_ZERO, 16'h7f00, 16'h0000, 2'h2, 3'h3, 1'b1,
           rel(2'h2, 8'h7f));
        go(BT_OP_ACC_ZERO, 16'h7f00, 16'h0100, 2'h2, 3'h2, 1'b0,
           16'h2002);
        go(BT_OP_ACC_NZ, 16'h7f00, 16'h0100, 2'h2, 3'h3, 1'b1,
           rel(2'h2, 8'h7f));
        go(BT_OP_ACC_NZ, 16'h7f00, 16'h0000, 2'h2, 3'h2, 1'b0,
           16'h2002);
        go(BT_OP_CMP_DIR, 16'h00f0, 16'h0506, 2'h3, 3'h5, 1'b1,
           16'h1ff3);
        go(BT_OP_CMP_DIR, 16'h00f0, 16'h0505, 2'h3, 3'h4, 1'b0,
           16'h2003);
        // operand value disagrees with acc so the wrong source shows
        go(BT_OP_CMP_ACC, 16'h4410, 16'h4544, 2'h3, 3'h4, 1'b1,
           16'h2013);
        go(BT_OP_CMP_ACC, 16'h4410, 16'h4400, 2'h3, 3'h3, 1'b0,
           16'h2003);
        go(BT_OP_CMP_REG, 16'h4410, 16'h4445, 2'h3, 3'h4, 1'b1,
           16'h2013);
        go(BT_OP_CMP_REG, 16'h4410, 16'h0044, 2'h3, 3'h3, 1'b0,
           16'h2003);
        go(BT_OP_CMP_IND, 16'h4410, 16'h4445, 2'h3, 3'h4, 1'b1,
           16'h2013);
        go(BT_OP_CMP_IND, 16'h4410, 16'h0044, 2'h3, 3'h3, 1'b0,
           16'h2003);
        // zero wraps to ff and still branches
        go(BT_OP_DEC_REG, 16'h0500, 16'h0000, 2'h2, 3'h3, 1'b1,
           16'h2007);
        go(BT_OP_DEC_REG, 16'h0500, 16'h0001, 2'h2, 3'h2, 1'b0,
           16'h2002);
        go(BT_OP_DEC_DIR, 16'h00fe, 16'h0002, 2'h3, 3'h4, 1'b1,
           16'h2001);
        go(BT_OP_DEC_DIR, 16'h00fe, 16'h0000, 2'h3, 3'h4, 1'b1,
           16'h2001);
        go(BT_OP_DEC_DIR, 16'h00fe, 16'h0001, 2'h3, 3'h3, 1'b0,
           16'h2003);
    endtask

    // back to back: request held high across busy must be ignored
    task automatic s_chain();
        chain_v = 1'b1;
        go(BT_OP_SHORT, 16'h1000, 16'h0000, 2'h2, 3'h3, 1'b1,
           16'h2012);
        go(BT_OP_ACC_ZERO, 16'h1000, 16'h0100, 2'h2, 3'h2, 1'b0,
           16'h2002);
        chain_v = 1'b0;
        go(BT_OP_DEC_REG, 16'h1000, 16'h0080, 2'h2, 3'h3, 1'b1,
           16'h2012);
    endtask

    // reset mid-instruction clears everything without a clock
    task automatic s_reset_mid();
        issue = '{op: BT_OP_LONG, hi3: 3'h0, b1: 8'h55, b2: 8'haa, pc: pc_v};
        issue_valid = 1'b1;
        @(posedge core_clk) #1;
        issue_valid = 1'b0;
        @(posedge core_clk) #1;
        resetn = 1'b0;
        #2;
        `CHK(busy, 1'b0)
        `CHK(done, 1'b0)
        `CHK(result, '0)
        @(posedge core_clk) #1;
        resetn = 1'b1;
        @(posedge core_clk) #1;
        `CHK(busy, 1'b0)
        go(BT_OP_LONG, 16'h55aa, 16'h0000, 2'h3, 3'h4, 1'b1, 16'h55aa);
    endtask

    // main sequence
    initial
    begin
        err_count = 0;
        n_tests = 0;
        resetn = 1'b0;
        issue_valid = 1'b0;
        issue = '0;
        acc = 8'h00;
        data_pointer_val = 16'h0000;
        opnd = 8'h00;
        stack_pc = 16'h0000;
        pc_v = 16'h2000;
        hi3_v = 3'h0;
        chain_v = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        `CHK(busy, 1'b0)
        `CHK(result, '0)
        resetn = 1'b1;
        @(posedge core_clk) #1;
        `CHK(busy, 1'b0)
        `CHK(done, 1'b0)
        `CHK(result, '0)
        s_uncond();
        s_cond();
        s_chain();
        s_reset_mid();
        summarize();
    end
endmodule
